// ---- rtl/lemc_pkg.sv ----
// constants, register map and carrier types for the laser enable and mode control
package lemc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_ERROR_EVENT_FLAGS  = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL_STATE_FLAGS = 8'h01;
  localparam logic [7:0] ADDR_CHANNEL_CTRL       = 8'h10;
  localparam logic [7:0] ADDR_SHUNT_RANGE        = 8'h13;
  localparam logic [7:0] ADDR_SHUNT_GAIN         = 8'h15;
  localparam logic [7:0] ADDR_OPERATING_STATE    = 8'h1c;
  localparam logic [7:0] ADDR_ERROR_MASK         = 8'h1d;
  localparam logic [7:0] ADDR_CHANNEL_MASK       = 8'h1e;

  // field positions
  localparam int BIT_CURRENT_CONTROL = 0;
  localparam int BIT_CHANNEL_INHIBIT = 3;
  localparam int BIT_SHUNT_RANGE     = 2;
  localparam int BIT_DIODE_POLARITY  = 7;
  localparam int BIT_GAIN_LSB        = 6;

  // error_event_flags bits
  localparam int ERR_RAM_INIT        = 0;
  localparam int ERR_CORE_SUPPLY     = 1;
  localparam int ERR_MEMORY_CHECK    = 2;
  localparam int ERR_OVERTEMP        = 3;
  localparam int ERR_LASER_SUPPLY    = 4;
  localparam int ERR_OVERCURRENT     = 5;
  localparam int ERR_OSCILLATOR      = 6;
  localparam int ERR_CONFIG_TIMEOUT  = 7;

  // channel_state_flags bits
  localparam int CHS_ACTIVE          = 0;
  localparam int CHS_EVER_ENABLED    = 1;
  localparam int CHS_ENABLE_PIN      = 2;
  localparam int CHS_FEEDBACK        = 3;

  // operating state codes
  localparam logic [1:0] MODE_OPERATION = 2'h1;
  localparam logic [1:0] MODE_CONFIG    = 2'h2;

  // values after reset
  localparam logic [1:0] RESET_MODE        = 2'h1;
  localparam logic [7:0] RESET_ERROR_FLAGS = 8'h03;
  localparam logic [7:0] RESET_ERROR_MASK  = 8'h00;
  localparam logic [3:0] RESET_CHAN_MASK   = 4'h0;

  // configuration timeout in oscillator pulses
  localparam int CFG_TIMEOUT_PULSES = 16400;
  localparam int CFG_COUNT_W        = 15;

  typedef struct packed {
    logic       current_control_select;
    logic       channel_inhibit;
    logic       diode_polarity_select;
    logic       shunt_voltage_range_select;
    logic [1:0] shunt_gain_select;
  } lemc_cfg_s;

  localparam lemc_cfg_s RESET_CFG = '{
    current_control_select:     1'b0,
    channel_inhibit:            1'b1,
    diode_polarity_select:      1'b0,
    shunt_voltage_range_select: 1'b0,
    shunt_gain_select:          2'h0
  };

  // asynchronous analog and pin events
  typedef struct packed {
    logic laser_enable_pin;
    logic interface_pin_open_error;
    logic standby;
    logic overtemp;
    logic overcurrent;
    logic laser_supply_drop;
    logic oscillator_fault;
    logic memory_check_fail;
    logic current_feedback_status;
  } lemc_evt_s;

  typedef enum logic [1:0] {
    LEMC_OPERATION,
    LEMC_CONFIG,
    LEMC_FORBIDDEN
  } lemc_mode_e;

endpackage

// ---- rtl/lemc_sync.sv ----
// two flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module lemc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = i_async;
    next_sync   = stage1;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end

endmodule // lemc_sync
`default_nettype wire

// ---- rtl/lemc_top.sv ----
// mode selection, channel enable gating and status reporting of the laser driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - select 01 operates, 10 configures, others error
// - operation applies stored config; configuration holds it
// - config writes stay inactive until operation
// - channel needs enable pin high, inhibit low
// - channel inhibit resets to one
// - bit 0 selects power or current regulation
// - floating interface select pin disables channel
// - status changes shown on alert pin unless masked
// - error status register bit layout
// - channel status register bit layout
// - status read acknowledges; pending events block channel
// - power-on sets ram init and core supply
// - standby exit sets core supply flag
// - overcurrent or overtemperature disables channel
// - memory error or config timeout disables channel
// - gain codes select 2, 5, 10, 50
// - range bit selects low or supply range
// - polarity ignored under current regulation
// - config mode times out after 16400 pulses
module lemc_top #(
  parameter int CFG_TIMEOUT = lemc_pkg::CFG_TIMEOUT_PULSES
) (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_wdata,
  output var  logic [7:0]         o_reg_rdata,
  output var  logic               o_reg_rvalid,
  input  wire lemc_pkg::lemc_evt_s i_events,
  output var  lemc_pkg::lemc_cfg_s o_active_cfg,
  output var  logic [5:0]         o_gain_factor,
  output var  logic               o_config_mode,
  output var  logic               o_channel_enable,
  output var  logic               o_error_alert_n
);
  import lemc_pkg::*;

  localparam int EVT_W = $bits(lemc_evt_s);

  function automatic logic [5:0] gain_factor(input logic [1:0] code);
    case (code)
      2'h0:    gain_factor = 6'h02;
      2'h1:    gain_factor = 6'h05;
      2'h2:    gain_factor = 6'h0a;
      default: gain_factor = 6'h32;
    endcase
  endfunction

  function automatic lemc_mode_e decode_mode(input logic [1:0] code);
    if (code == MODE_OPERATION) begin
      decode_mode = LEMC_OPERATION;
    end else if (code == MODE_CONFIG) begin
      decode_mode = LEMC_CONFIG;
    end else begin
      decode_mode = LEMC_FORBIDDEN;
    end
  endfunction

  // pin and analog events cross in from outside the clock domain
  logic [EVT_W-1:0] evt_sync_raw;
  lemc_evt_s        evt;

  lemc_sync #(
    .WIDTH (EVT_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_events),
    .o_sync  (evt_sync_raw)
  );

  assign evt = lemc_evt_s'(evt_sync_raw);

  // state
  lemc_cfg_s              stored_cfg;
  lemc_cfg_s              next_stored_cfg;
  lemc_cfg_s              next_active_cfg;
  logic [1:0]             mode_code;
  logic [1:0]             next_mode_code;
  logic [7:0]             error_mask;
  logic [7:0]             next_error_mask;
  logic [3:0]             channel_mask;
  logic [3:0]             next_channel_mask;
  logic [7:0]             error_flags;
  logic [7:0]             next_error_flags;
  logic                   ever_enabled;
  logic                   next_ever_enabled;
  logic                   channel_unread;
  logic                   next_channel_unread;
  logic [3:0]             channel_flags;
  logic [3:0]             prev_channel_flags;
  logic [3:0]             next_prev_channel_flags;
  logic [7:0]             alert_pend0;
  logic [7:0]             next_alert_pend0;
  logic [3:0]             alert_pend1;
  logic [3:0]             next_alert_pend1;
  logic                   standby_prev;
  logic                   next_standby_prev;
  logic [CFG_COUNT_W-1:0] cfg_count;
  logic [CFG_COUNT_W-1:0] next_cfg_count;
  logic                   cfg_timeout_pulse;
  logic [7:0]             next_rdata;
  logic                   next_rvalid;
  logic [5:0]             next_gain_factor;
  logic                   next_config_mode;
  logic                   next_channel_enable;
  logic                   next_alert_n;
  lemc_mode_e             mode;
  logic                   rd_error;
  logic                   rd_channel;
  logic                   cfg_write;

  assign mode       = decode_mode(mode_code);
  assign rd_error   = i_reg_rd && (i_reg_addr == ADDR_ERROR_EVENT_FLAGS);
  assign rd_channel = i_reg_rd && (i_reg_addr == ADDR_CHANNEL_STATE_FLAGS);
  // config writes gated
  // channel control, shunt range and shunt gain writes are blocked outside configuration mode; mode and mask writes are not
  assign cfg_write  = i_reg_wr && (mode == LEMC_CONFIG);

  always_comb begin
    channel_flags                   = 4'h0;
    channel_flags[CHS_ACTIVE]       = o_channel_enable;
    channel_flags[CHS_EVER_ENABLED] = ever_enabled;
    channel_flags[CHS_ENABLE_PIN]   = evt.laser_enable_pin;
    channel_flags[CHS_FEEDBACK]     = evt.current_feedback_status;
  end

  // configuration registers and mode select
  always_comb begin
    next_stored_cfg   = stored_cfg;
    next_mode_code    = mode_code;
    next_error_mask   = error_mask;
    next_channel_mask = channel_mask;
    if (i_reg_wr && (i_reg_addr == ADDR_OPERATING_STATE)) begin
      next_mode_code = i_reg_wdata[1:0];
    end else if (i_reg_wr && (i_reg_addr == ADDR_ERROR_MASK)) begin
      next_error_mask = i_reg_wdata;
    end else if (i_reg_wr && (i_reg_addr == ADDR_CHANNEL_MASK)) begin
      next_channel_mask = i_reg_wdata[3:0];
    end else if (cfg_write && (i_reg_addr == ADDR_CHANNEL_CTRL)) begin
      next_stored_cfg.current_control_select = i_reg_wdata[BIT_CURRENT_CONTROL];
      next_stored_cfg.channel_inhibit        = i_reg_wdata[BIT_CHANNEL_INHIBIT];
    end else if (cfg_write && (i_reg_addr == ADDR_SHUNT_RANGE)) begin
      next_stored_cfg.shunt_voltage_range_select = i_reg_wdata[BIT_SHUNT_RANGE];
      next_stored_cfg.diode_polarity_select      = i_reg_wdata[BIT_DIODE_POLARITY];
    end else if (cfg_write && (i_reg_addr == ADDR_SHUNT_GAIN)) begin
      next_stored_cfg.shunt_gain_select = i_reg_wdata[BIT_GAIN_LSB+1:BIT_GAIN_LSB];
    end
  end

  // transparent in operation
  // configuration and forbidden codes both hold what was last applied
  always_comb begin
    next_active_cfg = o_active_cfg;
    if (mode == LEMC_OPERATION) begin
      next_active_cfg = stored_cfg;
      if (stored_cfg.current_control_select) begin
        next_active_cfg.diode_polarity_select = 1'b0;
      end
    end
    next_gain_factor = gain_factor(next_active_cfg.shunt_gain_select);
    next_config_mode = (mode == LEMC_CONFIG);
  end

  always_comb begin
    next_cfg_count    = cfg_count;
    cfg_timeout_pulse = 1'b0;
    if (mode != LEMC_CONFIG) begin
      next_cfg_count = '0;
    end else if (cfg_count == CFG_COUNT_W'(CFG_TIMEOUT - 1)) begin
      // fires once per visit, then waits for the mode to change
      cfg_timeout_pulse = 1'b1;
      next_cfg_count    = CFG_COUNT_W'(CFG_TIMEOUT);
    end else if (cfg_count < CFG_COUNT_W'(CFG_TIMEOUT - 1)) begin
      next_cfg_count = cfg_count + CFG_COUNT_W'(1);
    end
  end

  always_comb begin
    next_standby_prev = evt.standby;
    next_error_flags  = error_flags;
    if (rd_error) begin
      next_error_flags = 8'h00;
    end
    // sets are applied after the clear so an event in the read cycle survives
    // standby exit flag
    if (standby_prev && !evt.standby) begin
      next_error_flags[ERR_CORE_SUPPLY] = 1'b1;
    end
    if ((mode == LEMC_FORBIDDEN) || evt.memory_check_fail) begin
      next_error_flags[ERR_MEMORY_CHECK] = 1'b1;
    end
    if (evt.overtemp) begin
      next_error_flags[ERR_OVERTEMP] = 1'b1;
    end
    if (evt.laser_supply_drop) begin
      next_error_flags[ERR_LASER_SUPPLY] = 1'b1;
    end
    if (evt.overcurrent) begin
      next_error_flags[ERR_OVERCURRENT] = 1'b1;
    end
    if (evt.oscillator_fault) begin
      next_error_flags[ERR_OSCILLATOR] = 1'b1;
    end
    if (cfg_timeout_pulse) begin
      next_error_flags[ERR_CONFIG_TIMEOUT] = 1'b1;
    end
  end

  // channel gating
  always_comb begin
    next_channel_enable = 1'b0;
    if ((mode == LEMC_OPERATION) && evt.laser_enable_pin &&
        !o_active_cfg.channel_inhibit) begin
      next_channel_enable = 1'b1;
    end
    if (evt.interface_pin_open_error) begin
      next_channel_enable = 1'b0;
    end
    if ((error_flags != 8'h00) || channel_unread) begin
      next_channel_enable = 1'b0;
    end
    next_channel_unread = channel_unread && !rd_channel;
    next_ever_enabled   = ever_enabled;
    if (rd_channel) begin
      next_ever_enabled = 1'b0;
    end
    if (next_channel_enable) begin
      next_ever_enabled = 1'b1;
    end
  end

  always_comb begin
    next_prev_channel_flags = channel_flags;
    next_alert_pend0        = alert_pend0;
    next_alert_pend1        = alert_pend1;
    if (rd_error) begin
      next_alert_pend0 = 8'h00;
    end
    if (rd_channel) begin
      next_alert_pend1 = 4'h0;
    end
    next_alert_pend0 = next_alert_pend0 | ((next_error_flags ^ error_flags) & ~error_mask);
    next_alert_pend1 = next_alert_pend1 | ((channel_flags ^ prev_channel_flags) & ~channel_mask);
    next_alert_n     = !((next_alert_pend0 != 8'h00) || (next_alert_pend1 != 4'h0));
  end

  // register read port
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = i_reg_rd;
    if (i_reg_addr == ADDR_ERROR_EVENT_FLAGS) begin
      next_rdata = error_flags;
    end else if (i_reg_addr == ADDR_CHANNEL_STATE_FLAGS) begin
      next_rdata = {4'h0, channel_flags};
    end else if (i_reg_addr == ADDR_CHANNEL_CTRL) begin
      next_rdata[BIT_CURRENT_CONTROL] = stored_cfg.current_control_select;
      next_rdata[BIT_CHANNEL_INHIBIT] = stored_cfg.channel_inhibit;
    end else if (i_reg_addr == ADDR_SHUNT_RANGE) begin
      next_rdata[BIT_SHUNT_RANGE]    = stored_cfg.shunt_voltage_range_select;
      next_rdata[BIT_DIODE_POLARITY] = stored_cfg.diode_polarity_select;
    end else if (i_reg_addr == ADDR_SHUNT_GAIN) begin
      next_rdata[BIT_GAIN_LSB+1:BIT_GAIN_LSB] = stored_cfg.shunt_gain_select;
    end else if (i_reg_addr == ADDR_OPERATING_STATE) begin
      next_rdata[1:0] = mode_code;
    end else if (i_reg_addr == ADDR_ERROR_MASK) begin
      next_rdata = error_mask;
    end else if (i_reg_addr == ADDR_CHANNEL_MASK) begin
      next_rdata = {4'h0, channel_mask};
    end
    if (!i_reg_rd) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stored_cfg         <= RESET_CFG;
      o_active_cfg       <= RESET_CFG;
      mode_code          <= RESET_MODE;
      error_mask         <= RESET_ERROR_MASK;
      channel_mask       <= RESET_CHAN_MASK;
      error_flags        <= RESET_ERROR_FLAGS;
      alert_pend0        <= RESET_ERROR_FLAGS;
      alert_pend1        <= 4'h0;
      channel_unread     <= 1'b1;
      ever_enabled       <= 1'b0;
      prev_channel_flags <= 4'h0;
      standby_prev       <= 1'b0;
      cfg_count          <= '0;
      o_reg_rdata        <= 8'h00;
      o_reg_rvalid       <= 1'b0;
      o_gain_factor      <= 6'h02;
      o_config_mode      <= 1'b0;
      o_channel_enable   <= 1'b0;
      o_error_alert_n    <= 1'b0;
    end else begin
      stored_cfg         <= next_stored_cfg;
      o_active_cfg       <= next_active_cfg;
      mode_code          <= next_mode_code;
      error_mask         <= next_error_mask;
      channel_mask       <= next_channel_mask;
      error_flags        <= next_error_flags;
      alert_pend0        <= next_alert_pend0;
      alert_pend1        <= next_alert_pend1;
      channel_unread     <= next_channel_unread;
      ever_enabled       <= next_ever_enabled;
      prev_channel_flags <= next_prev_channel_flags;
      standby_prev       <= next_standby_prev;
      cfg_count          <= next_cfg_count;
      o_reg_rdata        <= next_rdata;
      o_reg_rvalid       <= next_rvalid;
      o_gain_factor      <= next_gain_factor;
      o_config_mode      <= next_config_mode;
      o_channel_enable   <= next_channel_enable;
      o_error_alert_n    <= next_alert_n;
    end
  end

endmodule // lemc_top
`default_nettype wire

// ---- testbench/lemc_host_model.sv ----
// host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module lemc_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid,
  output var  logic [7:0] o_reg_addr,
  output var  logic       o_reg_wr,
  output var  logic       o_reg_rd,
  output var  logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // idle lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
  endtask
endmodule // lemc_host_model
`default_nettype wire

// ---- testbench/lemc_top_properties.sv ----
// assertions on the ports of the laser enable and mode control block
`timescale 1ns/1ps
`default_nettype none
module lemc_top_properties #(
  parameter int CFG_TIMEOUT = 16400
) (
  input wire logic                i_clk,
  input wire logic                i_srst,
  input wire logic [7:0]          i_reg_addr,
  input wire logic                i_reg_wr,
  input wire logic                i_reg_rd,
  input wire logic [7:0]          i_reg_wdata,
  input wire logic [7:0]          o_reg_rdata,
  input wire logic                o_reg_rvalid,
  input wire lemc_pkg::lemc_evt_s i_events,
  input wire lemc_pkg::lemc_cfg_s o_active_cfg,
  input wire logic [5:0]          o_gain_factor,
  input wire logic                o_config_mode,
  input wire logic                o_channel_enable,
  input wire logic                o_error_alert_n
);
  import lemc_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  function automatic logic [5:0] gain_of(input logic [1:0] g);
    return (g == 2'h0) ? 6'h02 : (g == 2'h1) ? 6'h05 : (g == 2'h2) ? 6'h0a : 6'h32;
  endfunction
  // windows cover the two sync flops plus flag and enable registers
  sequence s_pin_low;
    !i_events.laser_enable_pin [*5];
  endsequence
  sequence s_fault;
    (i_events.overtemp || i_events.overcurrent) [*6];
  endsequence
  sequence s_gain_settled;
    $stable(o_active_cfg.shunt_gain_select) [*2];
  endsequence
  AST_RESET_CFG: assert property ($fell(i_srst) |-> o_active_cfg == lemc_cfg_s'(6'h10))
    else $error("active configuration wrong after reset");
  AST_PIN_LOW: assert property (s_pin_low |-> !o_channel_enable)
    else $error("channel on with enable pin low");
  AST_INHIBIT: assert property (o_active_cfg.channel_inhibit |=> !o_channel_enable)
    else $error("channel on while inhibited");
  AST_OPEN_PIN: assert property (i_events.interface_pin_open_error [*6] |-> !o_channel_enable)
    else $error("channel on with open select pin");
  AST_FAULT_OFF: assert property (s_fault |-> !o_channel_enable)
    else $error("channel on during overcurrent or overtemperature");
  AST_CONFIG_OFF: assert property (o_config_mode |-> !o_channel_enable)
    else $error("channel on in configuration mode");
  AST_CONFIG_HOLD: assert property (o_config_mode && $past(o_config_mode) |-> $stable(o_active_cfg))
    else $error("active configuration changed in configuration mode");
  AST_GAIN: assert property (s_gain_settled |-> o_gain_factor == gain_of(o_active_cfg.shunt_gain_select))
    else $error("gain factor does not match gain code");
  AST_POLARITY: assert property (o_active_cfg.current_control_select |-> !o_active_cfg.diode_polarity_select)
    else $error("polarity applied under current regulation");
  AST_ALERT_HOLD: assert property (!o_error_alert_n && !i_reg_rd && !i_reg_wr |=> !o_error_alert_n)
    else $error("alert released without a read");
  AST_READ_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered next cycle");
endmodule // lemc_top_properties
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking testbench for the laser enable and mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lemc_pkg::*;
  localparam int CFG_T = 20;
  logic       i_clk = 1'b0;
  logic       i_srst = 1'b1;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv;
  logic       i_reg_wr, i_reg_rd, o_reg_rvalid, o_config_mode, o_channel_enable, o_error_alert_n;
  lemc_evt_s  i_events = '0;
  lemc_cfg_s  o_active_cfg;
  logic [5:0] o_gain_factor;
  int         bad_count = 0;
  int         samples_checked = 0;
  always #5 i_clk = ~i_clk;
  lemc_top #(.CFG_TIMEOUT(CFG_T)) lemc_top_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_events(i_events), .o_active_cfg(o_active_cfg), .o_gain_factor(o_gain_factor),
    .o_config_mode(o_config_mode), .o_channel_enable(o_channel_enable),
    .o_error_alert_n(o_error_alert_n));
  lemc_host_model lemc_host_model_inst (.i_clk(i_clk), .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lemc_host_model_inst.wr(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    lemc_host_model_inst.rd(a, rv);
    check(rv, exp);
  endtask
  task automatic set_mode(input logic [7:0] m);
    wr(8'h1c, m);
    tick(3);
  endtask
  task automatic en_chk(input logic exp);
    check({7'h0, o_channel_enable}, {7'h0, exp});
  endtask
  // second reads leave every status register acknowledged
  task automatic ack_all();
    for (int i = 0; i < 4; i++) lemc_host_model_inst.rd(8'(i / 2), rv);
    tick(2);
  endtask
  task automatic t_reset();
    i_srst = 1'b1;
    tick(6);
    i_srst = 1'b0;
    check({2'h0, o_active_cfg}, 8'h10);
    check({2'h0, o_gain_factor}, 8'h02);
    check({7'h0, o_error_alert_n}, 8'h00);
    i_events.laser_enable_pin = 1'b1;
    rd_chk(8'h00, 8'h03);
    rd_chk(8'h01, 8'h04);
    ack_all();
    check({7'h0, o_error_alert_n}, 8'h01);
    en_chk(1'b0);
  endtask
  task automatic t_config();
    set_mode(8'h02);
    check({7'h0, o_config_mode}, 8'h01);
    wr(8'h10, 8'h01);
    wr(8'h13, 8'h84);
    wr(8'h15, 8'hc0);
    rd_chk(8'h10, 8'h01);
    rd_chk(8'h13, 8'h84);
    check({2'h0, o_active_cfg}, 8'h10);
    set_mode(8'h01);
    check({2'h0, o_active_cfg}, 8'h27);
    tick(2);
    en_chk(1'b1);
    rd_chk(8'h01, 8'h07);
    wr(8'h10, 8'h08);
    rd_chk(8'h10, 8'h01);
    i_events.laser_enable_pin = 1'b0;
    tick(5);
    en_chk(1'b0);
    i_events.laser_enable_pin = 1'b1;
    tick(4);
    en_chk(1'b1);
  endtask
  task automatic t_gain();
    logic [7:0] f [4];
    f = '{8'h02, 8'h05, 8'h0a, 8'h32};
    for (int g = 0; g < 4; g++) begin
      set_mode(8'h02);
      wr(8'h15, 8'(g << 6));
      set_mode(8'h01);
      check({2'h0, o_gain_factor}, f[g]);
    end
  endtask
  task automatic t_fault();
    int ev [5];
    int fl [5];
    ev = '{5, 4, 3, 2, 1};
    fl = '{3, 5, 4, 6, 2};
    for (int k = 0; k < 5; k++) begin
      ack_all();
      check({7'h0, o_error_alert_n}, 8'h01);
      i_events[ev[k]] = 1'b1;
      tick(6);
      en_chk(1'b0);
      check({7'h0, o_error_alert_n}, 8'h00);
      i_events[ev[k]] = 1'b0;
      tick(4);
      en_chk(1'b0);
      rd_chk(8'h00, 8'(1 << fl[k]));
      tick(3);
      en_chk(1'b1);
    end
  endtask
  task automatic t_mask();
    wr(8'h1d, 8'hff);
    wr(8'h1e, 8'h0f);
    ack_all();
    i_events.overcurrent = 1'b1;
    tick(5);
    check({7'h0, o_error_alert_n}, 8'h01);
    i_events.overcurrent = 1'b0;
    tick(4);
    rd_chk(8'h00, 8'h20);
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h00);
    tick(3);
  endtask
  task automatic t_timeout();
    set_mode(8'h02);
    tick(CFG_T + 5);
    set_mode(8'h01);
    tick(2);
    en_chk(1'b0);
    rd_chk(8'h00, 8'h80);
    tick(3);
    en_chk(1'b1);
  endtask
  task automatic t_forbid();
    for (int m = 0; m < 2; m++) begin
      wr(8'h1c, (m == 0) ? 8'h00 : 8'h03);
      tick(4);
      en_chk(1'b0);
      check({2'h0, o_active_cfg}, 8'h27);
      set_mode(8'h01);
      rd_chk(8'h00, 8'h04);
      tick(3);
      en_chk(1'b1);
    end
  endtask
  task automatic t_standby();
    i_events.standby = 1'b1;
    tick(4);
    i_events.standby = 1'b0;
    tick(5);
    en_chk(1'b0);
    rd_chk(8'h00, 8'h02);
    tick(3);
    en_chk(1'b1);
    i_events.interface_pin_open_error = 1'b1;
    tick(6);
    en_chk(1'b0);
    i_events.interface_pin_open_error = 1'b0;
    tick(5);
    en_chk(1'b1);
    i_events.current_feedback_status = 1'b1;
    tick(3);
    rd_chk(8'h01, 8'h0f);
    i_events.current_feedback_status = 1'b0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    t_reset();
    t_config();
    t_gain();
    t_fault();
    t_mask();
    t_timeout();
    t_forbid();
    t_standby();
    t_reset();
    end_of_test();
  end
endmodule // tb
bind lemc_top lemc_top_properties #(.CFG_TIMEOUT(CFG_TIMEOUT)) lemc_top_properties_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_events(i_events), .o_active_cfg(o_active_cfg),
  .o_gain_factor(o_gain_factor), .o_config_mode(o_config_mode),
  .o_channel_enable(o_channel_enable), .o_error_alert_n(o_error_alert_n));
`default_nettype wire
